// File: include/gpio_qual_regs.vh
`ifndef GPIO_QUAL_REGS_VH
`define GPIO_QUAL_REGS_VH

// byte offsets on the register bus
`define QUAL_CTRL_OFFSET      8'h00
`define QUAL_SEL_LOW_OFFSET   8'h04
`define QUAL_SEL_HIGH_OFFSET  8'h08
`define PERIPH_ROUTE_OFFSET   8'h0C
`define QUAL_LEVEL_OFFSET     8'h10

// reset values: all periods zero, all pins synchronize-only
`define QUAL_CTRL_RESET       32'h0000_0000
`define QUAL_SEL_RESET        32'h0000_0000
`define PERIPH_ROUTE_RESET    32'h0000_0000

// field layout
`define PERIOD_FIELD_W        8
`define PERIOD_COUNT_W        9
`define PIN_GROUP_SIZE        8
`define QUAL_SEL_W            2
`define PIN_TOTAL             32

// qualifier mode codes
`define QMODE_SYNC            2'h0
`define QMODE_THREE           2'h1
`define QMODE_SIX             2'h2
`define QMODE_ASYNC           2'h3

// sample history depth (six-sample mode needs six)
`define SAMPLE_HIST_W         6

// bus responses
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// File: rtl/sample_strobe_gen.v
`timescale 1ns/100ps
`default_nettype none
`include "gpio_qual_regs.vh"

// free-running divider; one strobe per sampling period for a group
module sample_strobe_gen (
    input  wire                         i_mclk,
    input  wire                         i_rst,
    input  wire [`PERIOD_FIELD_W-1:0]   i_period,
    output wire                         o_strobe
);
    reg  [`PERIOD_COUNT_W-1:0] count_q;
    reg                        strobe_q;
    wire [`PERIOD_COUNT_W-1:0] last_count;

    // period n means 2n cycles, so count 0 .. 2n-1
    assign last_count = {i_period, 1'b0} - 9'h001;

    // every cycle or every 2n cycles
    // '>=' keeps the counter sane when software shortens the period
    always @(posedge i_mclk) begin
        if (i_rst) begin
            count_q  <= 9'h000;
            strobe_q <= 1'b0;
        end else if (i_period == 8'h00) begin
            count_q  <= 9'h000;
            strobe_q <= 1'b1;
        end else if (count_q >= last_count) begin
            count_q  <= 9'h000;
            strobe_q <= 1'b1;
        end else begin
            count_q  <= count_q + 9'h001;
            strobe_q <= 1'b0;
        end
    end

    assign o_strobe = strobe_q;

endmodule // sample_strobe_gen
`default_nettype wire

// File: rtl/pin_qualifier.v
`timescale 1ns/100ps
`default_nettype none
`include "gpio_qual_regs.vh"

// one pin: three-flop synchroniser, then optional sampling window
module pin_qualifier (
    input  wire                     i_mclk,
    input  wire                     i_rst,
    input  wire                     i_pin,
    input  wire                     i_strobe,
    input  wire [`QUAL_SEL_W-1:0]   i_mode,
    output wire                     o_level
);
    reg                          meta_q;
    reg                          sync2_q;
    reg                          sync3_q;
    reg                          held_q;
    reg  [`SAMPLE_HIST_W-1:0]    hist_q;
    reg                          level_q;
    reg                          level_d;
    wire                         synced;

    // a change counts only once stages two and three agree
    assign synced = (sync2_q == sync3_q) ? sync3_q : held_q;

    always @(posedge i_mclk) begin
        if (i_rst) begin
            meta_q  <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            held_q  <= 1'b0;
            hist_q  <= 6'h00;
        end else begin
            meta_q  <= i_pin;
            sync2_q <= meta_q;
            sync3_q <= sync2_q;
            held_q  <= synced;
            if (i_strobe)
                hist_q <= {hist_q[4:0], synced};
        end
    end

    // in three- and six-sample modes, new level only on all-equal samples
    // short glitches leave the level alone
    always @* begin
        level_d = level_q;
        case (i_mode)
            `QMODE_THREE: begin
                if (&hist_q[2:0])
                    level_d = 1'b1;
                else if (~|hist_q[2:0])
                    level_d = 1'b0;
            end
            `QMODE_SIX: begin
                if (&hist_q)
                    level_d = 1'b1;
                else if (~|hist_q)
                    level_d = 1'b0;
            end
            // async on a gpio input acts as sync
            default: level_d = synced;
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_rst)
            level_q <= 1'b0;
        else
            level_q <= level_d;
    end

    assign o_level = level_q;

endmodule // pin_qualifier
`default_nettype wire

// File: rtl/gpio_input_qualifier.v
`timescale 1ns/100ps
`default_nettype none
`include "gpio_qual_regs.vh"

module gpio_input_qualifier (
    input  wire                 i_mclk,
    input  wire                 i_rst,
    // axi4-lite write address
    input  wire [7:0]           i_awaddr,
    input  wire                 i_awvalid,
    output wire                 o_awready,
    // axi4-lite write data
    input  wire [31:0]          i_wdata,
    input  wire [3:0]           i_wstrb,
    input  wire                 i_wvalid,
    output wire                 o_wready,
    // axi4-lite write response
    output wire [1:0]           o_bresp,
    output wire                 o_bvalid,
    input  wire                 i_bready,
    // axi4-lite read address
    input  wire [7:0]           i_araddr,
    input  wire                 i_arvalid,
    output wire                 o_arready,
    // axi4-lite read data
    output wire [31:0]          o_rdata,
    output wire [1:0]           o_rresp,
    output wire                 o_rvalid,
    input  wire                 i_rready,
    // pins and qualified levels
    input  wire [31:0]          i_pin,
    output wire [31:0]          o_gpio_level,
    output wire [31:0]          o_periph_level
);

    // the register layout fixes the pin count at 32
    localparam PIN_COUNT   = `PIN_TOTAL;
    localparam GROUP_COUNT = PIN_COUNT / `PIN_GROUP_SIZE;

    // software-visible configuration
    reg  [31:0]                 port_qualifier_control_q;
    reg  [31:0]                 port_qual_select_low_q;
    reg  [31:0]                 port_qual_select_high_q;
    reg  [31:0]                 periph_route_q;

    // write channel state
    reg                         awready_q;
    reg                         wready_q;
    reg                         aw_held_q;
    reg                         w_held_q;
    reg  [7:0]                  awaddr_q;
    reg  [31:0]                 wdata_q;
    reg  [3:0]                  wstrb_q;
    reg                         bvalid_q;
    reg  [1:0]                  bresp_q;

    // read channel state
    reg                         arready_q;
    reg                         rvalid_q;
    reg  [31:0]                 rdata_q;
    reg  [1:0]                  rresp_q;
    reg  [31:0]                 read_word;
    reg                         read_hit;

    // per-pin and per-group wiring
    wire [63:0]                 qual_select_all;
    wire [GROUP_COUNT-1:0]      group_strobe;
    wire [PIN_COUNT-1:0]        qual_level;
    reg  [PIN_COUNT-1:0]        periph_level_d;

    // byte-lane merge for wstrb
    function [31:0] merge_bytes;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0]  strb;
        integer      k;
        begin
            merge_bytes = old_word;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k])
                    merge_bytes[k*8 +: 8] = new_word[k*8 +: 8];
            end
        end
    endfunction

    // all selects as one vector, two bits per pin
    assign qual_select_all = {port_qual_select_high_q, port_qual_select_low_q};

    // one period counter per group of eight pins
    genvar g;
    generate
        for (g = 0; g < GROUP_COUNT; g = g + 1) begin : g_group
            // full eight-bit field, 0 to 255
            sample_strobe_gen u_strobe (
                .i_mclk   (i_mclk),
                .i_rst    (i_rst),
                .i_period (port_qualifier_control_q[g*`PERIOD_FIELD_W +: `PERIOD_FIELD_W]),
                .o_strobe (group_strobe[g])
            );
        end
    endgenerate

    // one qualifier per pin, fed by its group's strobe
    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p = p + 1) begin : g_pin
            pin_qualifier u_qual (
                .i_mclk   (i_mclk),
                .i_rst    (i_rst),
                .i_pin    (i_pin[p]),
                .i_strobe (group_strobe[p / `PIN_GROUP_SIZE]),
                .i_mode   (qual_select_all[p*`QUAL_SEL_W +: `QUAL_SEL_W]),
                .o_level  (qual_level[p])
            );
        end
    endgenerate

    // peripheral view of each pin
    // the async path is the only output not from a flop: it must
    // bypass the clock entirely to work without it
    integer n;
    always @* begin
        for (n = 0; n < PIN_COUNT; n = n + 1) begin
            if (periph_route_q[n] &&
                qual_select_all[n*2 +: 2] == `QMODE_ASYNC)
                periph_level_d[n] = i_pin[n];
            else
                periph_level_d[n] = qual_level[n];
        end
    end

    // address and data are taken in either order, then written together
    always @(posedge i_mclk) begin
        if (i_rst) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
        end else begin
            if (i_awvalid && awready_q) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= i_awaddr;
                awready_q <= 1'b0;
            end
            if (i_wvalid && wready_q) begin
                w_held_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
                wready_q <= 1'b0;
            end
            // both halves present: answer next cycle
            if (aw_held_q && w_held_q && !bvalid_q) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                case (awaddr_q)
                    `QUAL_CTRL_OFFSET,
                    `QUAL_SEL_LOW_OFFSET,
                    `QUAL_SEL_HIGH_OFFSET,
                    `PERIPH_ROUTE_OFFSET: bresp_q <= `RESP_OKAY;
                    // level register is read-only; unmapped too
                    default:              bresp_q <= `RESP_SLVERR;
                endcase
            end
            // ready again only after the response is taken
            if (bvalid_q && i_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // configuration registers, written when both halves are held
    always @(posedge i_mclk) begin
        if (i_rst) begin
            port_qualifier_control_q <= `QUAL_CTRL_RESET;
            port_qual_select_low_q   <= `QUAL_SEL_RESET;
            port_qual_select_high_q  <= `QUAL_SEL_RESET;
            periph_route_q           <= `PERIPH_ROUTE_RESET;
        end else if (aw_held_q && w_held_q && !bvalid_q) begin
            case (awaddr_q)
                `QUAL_CTRL_OFFSET:
                    port_qualifier_control_q <=
                        merge_bytes(port_qualifier_control_q, wdata_q, wstrb_q);
                `QUAL_SEL_LOW_OFFSET:
                    port_qual_select_low_q <=
                        merge_bytes(port_qual_select_low_q, wdata_q, wstrb_q);
                `QUAL_SEL_HIGH_OFFSET:
                    port_qual_select_high_q <=
                        merge_bytes(port_qual_select_high_q, wdata_q, wstrb_q);
                `PERIPH_ROUTE_OFFSET:
                    periph_route_q <=
                        merge_bytes(periph_route_q, wdata_q, wstrb_q);
                default: ;
            endcase
        end
    end

    // read decode; the level register shows live qualified state
    always @* begin
        read_word = 32'h0000_0000;
        read_hit  = 1'b1;
        case (i_araddr)
            `QUAL_CTRL_OFFSET:     read_word = port_qualifier_control_q;
            `QUAL_SEL_LOW_OFFSET:  read_word = port_qual_select_low_q;
            `QUAL_SEL_HIGH_OFFSET: read_word = port_qual_select_high_q;
            `PERIPH_ROUTE_OFFSET:  read_word = periph_route_q;
            `QUAL_LEVEL_OFFSET:    read_word = qual_level;
            default:               read_hit  = 1'b0;
        endcase
    end

    // one read at a time; data captured on the address handshake
    always @(posedge i_mclk) begin
        if (i_rst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `RESP_OKAY;
        end else begin
            if (i_arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= read_word;
                rresp_q   <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid_q && i_rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // bus outputs straight from their flops
    assign o_awready = awready_q;
    assign o_wready  = wready_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid  = rvalid_q;
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;

    // qualified levels for the core and for peripherals
    assign o_gpio_level   = qual_level;
    assign o_periph_level = periph_level_d;

endmodule // gpio_input_qualifier
`default_nettype wire

// File: tb/pin_source.sv
`timescale 1ns/100ps
`default_nettype none

// stands in for whatever drives the input pins from outside
module pin_source (
    input  wire logic        i_mclk,
    output var  logic [31:0] o_pins
);
    initial o_pins = 32'h0;

    // hold the level
    // a level is held for whole clock cycles; zero cycles returns at once
    task automatic drive(input int pin, input logic lvl, input int cycles);
        o_pins[pin] <= lvl;
        repeat (cycles) @(posedge i_mclk);
    endtask
endmodule // pin_source

`default_nettype wire

// File: tb/gpio_qual_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// bus handshake and qualified level checks at the block's ports
module gpio_qual_monitor (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [31:0] i_pin,
    input wire logic [31:0] o_gpio_level,
    input wire logic [31:0] o_periph_level
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_reset_level: assert property ($fell(i_rst) |-> o_gpio_level == 32'h0)
        else $error("level not clear after reset");
    // pin 0 stays in sync mode, so a change must match the recent pin
    a_sync_follow: assert property ($changed(o_gpio_level[0])
        |-> o_gpio_level[0] == $past(i_pin[0], 2)) else $error("sync level wrong");
    // where the two outputs differ, the peripheral copy is the raw pin
    a_periph_bypass: assert property (((o_periph_level ^ o_gpio_level)
        & (o_periph_level ^ i_pin)) == 32'h0) else $error("bypass level wrong");
    a_aw_taken: assert property (i_awvalid && o_awready |=> !o_awready)
        else $error("write address taken twice");
    a_write_resp: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |-> ##[1:3] o_bvalid) else $error("write response missing");
    a_b_release: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("write response not released");
    a_read_resp: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("read response missing");
    a_r_release: assert property (o_rvalid && i_rready |=> !o_rvalid)
        else $error("read response not released");

    c_six_rise: cover property ($rose(o_gpio_level[8]));
    c_slverr: cover property (o_bvalid && o_bresp == 2'h2);
    c_bypass: cover property ($rose(o_periph_level[9]));
    c_read: cover property (o_rvalid && i_rready && o_rdata != 32'h0);
endmodule // gpio_qual_monitor

bind gpio_input_qualifier gpio_qual_monitor u_mon (
    .i_mclk, .i_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
    .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
    .i_rready, .i_pin, .o_gpio_level, .o_periph_level
);

`default_nettype wire

// File: tb/gpio_input_qualifier_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_qual_regs.vh"

module gpio_input_qualifier_tb_top;
    logic        mclk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  awaddr = 8'h0;
    logic [7:0]  araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'h0;
    logic        wvalid = 1'h0;
    logic        bready = 1'h0;
    logic        arvalid = 1'h0;
    logic        rready = 1'h0;
    wire  [31:0] rdata, pins, gpio_lvl, periph_lvl;
    wire  [1:0]  bresp, rresp;
    wire         awready, wready, bvalid, arready, rvalid;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;

    gpio_input_qualifier dut (
        .i_mclk(mclk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_pin(pins), .o_gpio_level(gpio_lvl), .o_periph_level(periph_lvl)
    );
    pin_source src (.i_mclk(mclk), .o_pins(pins));

    initial forever #4 mclk = ~mclk;

    // the run needs well under a thousand cycles; a hang is cut off here
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // address and data go out together; each drops once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        fork
            begin
                do @(posedge mclk); while (!awready);
                awvalid <= 1'h0;
            end
            begin
                do @(posedge mclk); while (!wready);
                wvalid <= 1'h0;
            end
        join
        do @(posedge mclk); while (!bvalid);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge mclk); while (!rvalid);
        rready <= 1'h0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    task automatic wait_lvl(input int k, input logic v, input int n);
        for (int i = 0; i < n && gpio_lvl[k] !== v; i++)
            @(posedge mclk);
        chk(32'(gpio_lvl[k]), 32'(v));
    endtask

    // watches every cycle, so a short blip on the output is caught too
    task automatic hold_lvl(input int k, input logic v, input int n);
        logic bad;
        bad = 1'h0;
        repeat (n) begin
            @(posedge mclk);
            bad |= (gpio_lvl[k] !== v);
        end
        chk(32'(bad), 32'h0);
    endtask

    task automatic t_reset();
        for (int a = 0; a < 16; a += 4)
            rd(8'(a), 32'h0, `RESP_OKAY);
        chk(gpio_lvl, 32'h0);
    endtask

    task automatic t_sync();
        src.drive(0, 1'h1, 0);
        wait_lvl(0, 1'h1, 8);
        src.drive(0, 1'h0, 0);
        wait_lvl(0, 1'h0, 8);
    endtask

    // a two-cycle pulse survives the synchroniser but not three samples
    task automatic t_three();
        wr(`QUAL_SEL_LOW_OFFSET, 32'h0000_0004, `RESP_OKAY);
        src.drive(1, 1'h1, 2);
        src.drive(1, 1'h0, 0);
        hold_lvl(1, 1'h0, 12);
        src.drive(1, 1'h1, 0);
        wait_lvl(1, 1'h1, 12);
    endtask

    // eight cycles pass with one-cycle sampling but not with two
    task automatic t_six();
        wr(`QUAL_CTRL_OFFSET, 32'h0000_0100, `RESP_OKAY);
        wr(`QUAL_SEL_LOW_OFFSET, 32'h0002_0004, `RESP_OKAY);
        src.drive(8, 1'h1, 8);
        src.drive(8, 1'h0, 0);
        hold_lvl(8, 1'h0, 30);
        src.drive(8, 1'h1, 0);
        wait_lvl(8, 1'h1, 24);
    endtask

    task automatic t_async();
        wr(`QUAL_SEL_LOW_OFFSET, 32'h000E_0004, `RESP_OKAY);
        wr(`PERIPH_ROUTE_OFFSET, 32'h0000_0200, `RESP_OKAY);
        src.drive(9, 1'h1, 0);
        #1;
        chk(32'(periph_lvl[9]), 32'h1);
        chk(32'(gpio_lvl[9]), 32'h0);
        wait_lvl(9, 1'h1, 8);
    endtask

    task automatic t_regs();
        rd(`QUAL_SEL_LOW_OFFSET, 32'h000E_0004, `RESP_OKAY);
        wr(`QUAL_CTRL_OFFSET, 32'hFF00_0100, `RESP_OKAY);
        rd(`QUAL_CTRL_OFFSET, 32'hFF00_0100, `RESP_OKAY);
        // only byte lane one may change under a partial strobe
        wstrb <= 4'h2;
        wr(`QUAL_CTRL_OFFSET, 32'h1234_AA56, `RESP_OKAY);
        wstrb <= 4'hF;
        rd(`QUAL_CTRL_OFFSET, 32'hFF00_AA00, `RESP_OKAY);
        wr(`QUAL_LEVEL_OFFSET, 32'hFFFF_FFFF, `RESP_SLVERR);
        rd(8'h14, 32'h0, `RESP_SLVERR);
        rd(`QUAL_LEVEL_OFFSET, 32'h0000_0302, `RESP_OKAY);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        t_reset();
        t_sync();
        t_three();
        t_six();
        t_async();
        t_regs();
        report_and_stop();
    end
endmodule // gpio_input_qualifier_tb_top

`default_nettype wire
